/* core/tmc_overheat_pin_n_hyst.sv */
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// Overheat decision with hysteresis for one channel.
// ------------------------------------------------------------------
module tmc_overheat_pin_n_hyst (
  // Reading and limit in two's complement degrees, hysteresis unsigned.
  input wire logic [7:0] temp,
  input wire logic [7:0] limit,
  input wire logic [7:0] hyst,
  // Present and next overheat state.
  input wire logic hot,
  output logic nxt_hot
);

  logic signed [9:0] t_s;
  logic signed [9:0] l_s;
  logic signed [9:0] rel_s;

  // Ten bits keep limit minus any hysteresis up to 255 from wrapping.
  always_comb begin
    t_s = {{2{temp[7]}}, temp};
    l_s = {{2{limit[7]}}, limit};
    rel_s = l_s - $signed({2'b00, hyst});
    if (!hot) begin
      nxt_hot = (t_s > l_s);
    end else begin
      nxt_hot = !(t_s < rel_s); // R21
    end
  end

endmodule

`default_nettype wire

/* core/tmc_rate_timer.sv */
`timescale 1ns/100ps
`default_nettype none
`include "tmc_cfg.svh"

// ------------------------------------------------------------------
// Conversion-rate timer: one tick per conversion period.
// ------------------------------------------------------------------
module tmc_rate_timer #(
  parameter int unsigned BASE_CYCLES = `TMC_SLOW_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Control.
  input wire logic run,
  input wire logic [3:0] code,
  // Period tick.
  output logic tick
);

  tmc_pkg::tmc_timer_t st_ff;
  tmc_pkg::tmc_timer_t nxt_st;
  logic [31:0] period_last;

  // Each code step halves the period of the slowest rate.
  assign period_last = (32'(BASE_CYCLES) >> code) - 32'h0000_0001; // R11

  // Stopped, the count sits at zero so monitoring restarts at once.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (!run) begin
      nxt_st.cnt = 32'h0000_0000;
    end else if (st_ff.cnt == 32'h0000_0000) begin
      nxt_st.tick = 1'b1;
      nxt_st.cnt = period_last;
    end else begin
      nxt_st.cnt = st_ff.cnt - 32'h0000_0001;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

endmodule

`default_nettype wire

/* core/tmc_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "tmc_cfg.svh"

// Operation
// [R1] Configuration read and write at different indexes.
// [R2] Mask bit silences the alert pin.
// [R3] Stop bit halts monitoring, enters standby.
// [R4] Configuration bits five to one read zero.
// [R5] Sleep bit powers the whole device down.
// [R6] Status bit seven shows conversion busy.
// [R7] Status bits six to three show limits.
// [R8] Status bit two shows remote open circuit.
// [R9] Status bits one, zero show overheat.
// [R10] Rate read and write at different indexes.
// [R11] Rate code doubles conversions per step.
// [R12] One-shot write in standby runs one conversion.
// [R13] Timeout bit enables a 25 ms timeout.
// [R14] Queue field sets consecutive faults before alert.
// [R15] Coupling bit also requires alert-response service.
// [R16] Compensation bit seven enables beta compensation.
// [R17] Compensation bit six selects pad bias.
// [R18] Compensation bit three enables resistance cancellation.
// [R19] Transport address seven bits, top bit zero.
// [R20] Status read needed before alert releases.
// [R21] Overheat holds until below limit minus hysteresis.
// [R22] Old results stay readable during conversion.
// [R23] Stalled transaction resets the serial interface.
// [R24] Clean conversion zeroes the fault queue.
module tmc_top #(
  parameter int unsigned TMO_CYCLES = `TMC_TMO_CYC,
  parameter int unsigned SLOW_CYCLES = `TMC_SLOW_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register access, one index per request.
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_idx,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Serial interface supervision.
  input wire logic bus_busy,
  input wire logic bus_activity,
  input wire logic ara_serviced,
  output logic bus_timeout_reset,
  // Converter handshake and results.
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [4:0] limit_flags,
  input wire logic [7:0] local_sensor_temp,
  input wire logic [7:0] remote_diode_temp,
  input wire logic [7:0] local_overheat_pin_n_limit,
  input wire logic [7:0] local_overheat_pin_n_hyst,
  input wire logic [7:0] remote_overheat_pin_n_limit,
  input wire logic [7:0] remote_overheat_pin_n_hyst,
  // Pins and analog controls.
  output logic alert_pin_n,
  output logic overheat_pin_n,
  output logic device_sleep,
  output logic monitor_stop,
  output logic beta_comp_en,
  output logic bias_high_sel,
  output logic res_cancel_en,
  output logic [6:0] transport_target_address
);

  // ------------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------------
  // The fastest rate divides the base period by 1024.
  if (TMO_CYCLES < 2 || SLOW_CYCLES < 1024 || SLOW_CYCLES > 32'h7FFF_FFFF) begin : g_bad_param
    $error("tmc_top: timing parameter out of range");
  end

  localparam logic [31:0] TMO_LAST = 32'(TMO_CYCLES - 1);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  tmc_pkg::tmc_state_t st_ff; // All registered state.
  tmc_pkg::tmc_state_t nxt_st; // Next value of the state.
  logic run; // Continuous monitoring wanted.
  logic tick; // Conversion period elapsed.
  logic [3:0] rate_code; // Rate code clamped to the table.
  logic wr_cfg; // Write decodes.
  logic wr_rate;
  logic wr_os;
  logic wr_qt;
  logic wr_ara;
  logic wr_comp;
  logic wr_addr;
  logic stat_rd; // Status read, clears latched flags.
  logic os_go; // One-shot accepted.
  logic lhot_nxt; // Overheat decisions for the new reading.
  logic rhot_nxt;
  logic [2:0] need; // Faults needed before alert.
  logic [2:0] qinc; // Saturated fault count plus one.
  logic [7:0] rd_mux; // Read data selected by index.

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  assign run = !st_ff.stop && !st_ff.sleep; // R3 R5
  assign wr_cfg = reg_wr && (reg_idx == `TMC_IDX_CFG_WR); // R1
  assign wr_rate = reg_wr && (reg_idx == `TMC_IDX_RATE_WR); // R10
  assign wr_os = reg_wr && (reg_idx == `TMC_IDX_ONESHOT);
  assign wr_qt = reg_wr && (reg_idx == `TMC_IDX_QTMO);
  assign wr_ara = reg_wr && (reg_idx == `TMC_IDX_ARA);
  assign wr_comp = reg_wr && (reg_idx == `TMC_IDX_COMP);
  assign wr_addr = reg_wr && (reg_idx == `TMC_IDX_ADDR);
  assign stat_rd = reg_rd && (reg_idx == `TMC_IDX_STATUS);
  // A one-shot outside standby or during a conversion is dropped.
  assign os_go = wr_os && !run && (st_ff.conv == tmc_pkg::conv_idle); // R12

  // Reserved rate codes run at the fastest defined rate.
  assign rate_code = (st_ff.rate > `TMC_RATE_MAX) ? 4'hA : st_ff.rate[3:0]; // R11

  // Codes 000, 001, 011, 111 give one to four faults.
  assign need = 3'h1 + {2'h0, st_ff.queue[0]} + {2'h0, st_ff.queue[1]} + {2'h0, st_ff.queue[2]}; // R14
  assign qinc = (st_ff.qcnt == `TMC_QUEUE_MAX) ? st_ff.qcnt : st_ff.qcnt + 3'h1;

  // ------------------------------------------------------------------
  // Submodules
  // ------------------------------------------------------------------
  tmc_rate_timer #(
    .BASE_CYCLES(SLOW_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .run(run),
    .code(rate_code),
    .tick(tick)
  );

  tmc_overheat_pin_n_hyst u_local_hyst (
    .temp(local_sensor_temp),
    .limit(local_overheat_pin_n_limit),
    .hyst(local_overheat_pin_n_hyst),
    .hot(st_ff.lhot),
    .nxt_hot(lhot_nxt)
  );

  tmc_overheat_pin_n_hyst u_remote_hyst (
    .temp(remote_diode_temp),
    .limit(remote_overheat_pin_n_limit),
    .hyst(remote_overheat_pin_n_hyst),
    .hot(st_ff.rhot),
    .nxt_hot(rhot_nxt)
  );

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    // Read multiplexer; write-only and unmapped indexes read zero.
    case (reg_idx)
      `TMC_IDX_STATUS: rd_mux = {st_ff.conv == tmc_pkg::conv_busy, st_ff.flags, st_ff.rhot, st_ff.lhot}; // R6 R7 R8 R9
      `TMC_IDX_CFG_RD: rd_mux = {st_ff.mask, st_ff.stop, 5'h00, st_ff.sleep}; // R1 R4
      `TMC_IDX_RATE_RD: rd_mux = st_ff.rate; // R10
      `TMC_IDX_QTMO: rd_mux = {st_ff.tmo_en, 3'h0, st_ff.queue, 1'b1};
      `TMC_IDX_ARA: rd_mux = {7'h00, st_ff.ara_cpl};
      `TMC_IDX_COMP: rd_mux = st_ff.comp;
      `TMC_IDX_ADDR: rd_mux = {1'b0, st_ff.taddr}; // R19
      default: rd_mux = 8'h00;
    endcase

    nxt_st = st_ff;
    nxt_st.start = 1'b0;
    nxt_st.bus_rst = 1'b0;
    nxt_st.rvalid = 1'b0;

    // Register writes.
    if (wr_cfg) begin
      nxt_st.mask = reg_wdata[`TMC_CFG_MASK_BIT]; // R2
      nxt_st.stop = reg_wdata[`TMC_CFG_STOP_BIT]; // R3
      nxt_st.sleep = reg_wdata[`TMC_CFG_SLEEP_BIT]; // R5
    end
    if (wr_rate) begin
      nxt_st.rate = reg_wdata; // R10
    end
    if (wr_qt) begin
      nxt_st.tmo_en = reg_wdata[`TMC_QT_TMO_BIT]; // R13
      nxt_st.queue = reg_wdata[3:1]; // R14
    end
    if (wr_ara) begin
      nxt_st.ara_cpl = reg_wdata[`TMC_ARA_BIT]; // R15
    end
    if (wr_comp) begin
      // Spare bits are kept as plain storage.
      nxt_st.comp = reg_wdata; // R16 R17 R18
    end
    if (wr_addr) begin
      nxt_st.taddr = reg_wdata[6:0]; // R19
    end

    // Register reads answer one cycle later.
    if (reg_rd) begin
      nxt_st.rdata = rd_mux;
      nxt_st.rvalid = 1'b1;
    end

    // Conversion sequencer; a stop during a conversion lets it finish.
    unique case (st_ff.conv)
      tmc_pkg::conv_idle: begin
        if ((tick && run) || os_go) begin // R3 R12
          nxt_st.start = 1'b1;
          nxt_st.conv = tmc_pkg::conv_busy;
        end
      end
      tmc_pkg::conv_busy: begin
        if (adc_done) begin
          // Results replace the old ones only at completion.
          nxt_st.cond = limit_flags; // R22
          nxt_st.lhot = lhot_nxt; // R21
          nxt_st.rhot = rhot_nxt; // R21
          nxt_st.conv = tmc_pkg::conv_idle;
          if (|limit_flags) begin
            nxt_st.qcnt = qinc;
            if (qinc >= need) begin
              nxt_st.alert = 1'b1; // R14
            end
          end else begin
            nxt_st.qcnt = 3'h0; // R24
          end
        end
      end
    endcase

    // Latched flags: a live condition wins over the read clear.
    nxt_st.flags = (st_ff.flags & ~{5{stat_rd}}) | nxt_st.cond; // R7 R8 R20

    // Alert release needs clean flags and, if coupled, service.
    if (nxt_st.flags == 5'h00 && (!st_ff.ara_cpl || st_ff.ara_done)) begin // R15 R20
      nxt_st.alert = 1'b0;
    end
    if (!nxt_st.alert) begin
      nxt_st.ara_done = 1'b0;
    end else if (ara_serviced) begin
      nxt_st.ara_done = 1'b1; // R15
    end

    // Pins are registered from the next state.
    nxt_st.alert_pin_n = !(nxt_st.alert && !nxt_st.mask); // R2
    nxt_st.overheat_pin_n = !(nxt_st.lhot || nxt_st.rhot); // R9 R21

    // Serial timeout: any activity restarts the count.
    if (st_ff.tmo_en && bus_busy && !bus_activity) begin // R13
      if (st_ff.tmo_cnt == TMO_LAST) begin
        nxt_st.tmo_cnt = 32'h0000_0000;
        nxt_st.bus_rst = 1'b1; // R23
      end else begin
        nxt_st.tmo_cnt = st_ff.tmo_cnt + 32'h0000_0001;
      end
    end else begin
      nxt_st.tmo_cnt = 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.conv <= tmc_pkg::conv_idle;
      st_ff.rate <= `TMC_RATE_RST; // R11
      st_ff.ara_cpl <= `TMC_ARA_RST; // R15
      st_ff.comp <= `TMC_COMP_RST; // R16 R17 R18
      st_ff.taddr <= `TMC_ADDR_RST; // R19
      st_ff.alert_pin_n <= 1'b1;
      st_ff.overheat_pin_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ------------------------------------------------------------------
  // Outputs, each straight from the state register
  // ------------------------------------------------------------------
  assign reg_rdata = st_ff.rdata;
  assign reg_rvalid = st_ff.rvalid;
  assign bus_timeout_reset = st_ff.bus_rst;
  assign adc_start = st_ff.start;
  assign alert_pin_n = st_ff.alert_pin_n;
  assign overheat_pin_n = st_ff.overheat_pin_n;
  assign device_sleep = st_ff.sleep;
  assign monitor_stop = st_ff.stop;
  assign beta_comp_en = st_ff.comp[7]; // R16
  assign bias_high_sel = st_ff.comp[6]; // R17
  assign res_cancel_en = st_ff.comp[3]; // R18
  assign transport_target_address = st_ff.taddr; // R19

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_os_req;
    wr_os && !run && (st_ff.conv == tmc_pkg::conv_idle);
  endsequence

  sequence s_conv_begin;
    st_ff.start ##1 (st_ff.conv == tmc_pkg::conv_busy);
  endsequence

  property p_cfg_read;
    reg_rd && (reg_idx == `TMC_IDX_CFG_RD) |=> reg_rvalid && (reg_rdata[5:1] == 5'h00);
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("reserved config bits not zero"); // R4

  property p_mask;
    st_ff.mask |-> alert_pin_n;
  endproperty
  a_mask: assert property (p_mask) else $error("alert pin low while masked"); // R2

  property p_stop;
    !run && !wr_os |=> !adc_start;
  endproperty
  a_stop: assert property (p_stop) else $error("conversion started in standby"); // R3

  property p_sleep;
    wr_cfg |=> device_sleep == $past(reg_wdata[0]);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep bit not taken"); // R5

  property p_busy;
    reg_rd && (reg_idx == `TMC_IDX_STATUS) && (st_ff.conv == tmc_pkg::conv_busy) |=> reg_rdata[7];
  endproperty
  a_busy: assert property (p_busy) else $error("busy bit not shown"); // R6

  property p_oneshot;
    s_os_req |=> s_conv_begin;
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot did not start"); // R12

  property p_queue_clear;
    adc_done && (st_ff.conv == tmc_pkg::conv_busy) && (limit_flags == 5'h00) |=> st_ff.qcnt == 3'h0;
  endproperty
  a_queue_clear: assert property (p_queue_clear) else $error("fault queue not cleared"); // R24

  property p_queue_need;
    $rose(st_ff.alert) |-> st_ff.qcnt >= $past(need);
  endproperty
  a_queue_need: assert property (p_queue_need) else $error("alert before queue depth"); // R14

  property p_hold_flags;
    st_ff.alert && (st_ff.flags != 5'h00) && !stat_rd |=> st_ff.alert;
  endproperty
  a_hold_flags: assert property (p_hold_flags) else $error("alert released before status read"); // R20

  property p_hold_ara;
    st_ff.alert && st_ff.ara_cpl && !st_ff.ara_done |=> st_ff.alert;
  endproperty
  a_hold_ara: assert property (p_hold_ara) else $error("alert released without service"); // R15

  property p_timeout;
    bus_timeout_reset |-> $past(st_ff.tmo_cnt) == TMO_LAST && $past(st_ff.tmo_en);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout at wrong count"); // R23

  property p_overheat_pin_n_hold;
    st_ff.lhot && !adc_done |=> st_ff.lhot && !overheat_pin_n;
  endproperty
  a_overheat_pin_n_hold: assert property (p_overheat_pin_n_hold) else $error("overheat dropped without reading"); // R21

endmodule

`default_nettype wire

/* inc/tmc_cfg.svh */
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH

// ------------------------------------------------------------------
// Register indexes
// ------------------------------------------------------------------
`define TMC_IDX_STATUS 8'h02
`define TMC_IDX_CFG_RD 8'h03
`define TMC_IDX_CFG_WR 8'h09
`define TMC_IDX_RATE_RD 8'h04
`define TMC_IDX_RATE_WR 8'h0A
`define TMC_IDX_ONESHOT 8'h0F
`define TMC_IDX_QTMO 8'h22
`define TMC_IDX_ARA 8'h24
`define TMC_IDX_COMP 8'h3B
`define TMC_IDX_ADDR 8'h3D

// ------------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------------
`define TMC_CFG_MASK_BIT 7
`define TMC_CFG_STOP_BIT 6
`define TMC_CFG_SLEEP_BIT 0
`define TMC_QT_TMO_BIT 7
`define TMC_ARA_BIT 0
`define TMC_RATE_RST 8'h08
`define TMC_RATE_MAX 8'h0A
`define TMC_COMP_RST 8'h8A
`define TMC_ADDR_RST 7'h4C
`define TMC_ARA_RST 1'b1
`define TMC_QUEUE_MAX 3'h4

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define TMC_CLK_HZ 20000000
`define TMC_TMO_MS 25
`define TMC_TMO_CYC (`TMC_TMO_MS * (`TMC_CLK_HZ / 1000))
`define TMC_SLOW_PERIOD_MS 16000
`define TMC_SLOW_CYC (`TMC_SLOW_PERIOD_MS * (`TMC_CLK_HZ / 1000))

`endif

/* inc/tmc_pkg.sv */
package tmc_pkg;

  // ------------------------------------------------------------------
  // Conversion sequencer states, one-hot.
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    conv_idle = 2'b01,
    conv_busy = 2'b10
  } tmc_conv_t;

  // ------------------------------------------------------------------
  // Whole state of the control block.
  // ------------------------------------------------------------------
  typedef struct packed {
    tmc_conv_t conv;
    logic mask;
    logic stop;
    logic sleep;
    logic [7:0] rate;
    logic tmo_en;
    logic [2:0] queue;
    logic ara_cpl;
    logic [7:0] comp;
    logic [6:0] taddr;
    logic [4:0] cond;
    logic [4:0] flags;
    logic lhot;
    logic rhot;
    logic [2:0] qcnt;
    logic alert;
    logic ara_done;
    logic start;
    logic [31:0] tmo_cnt;
    logic bus_rst;
    logic [7:0] rdata;
    logic rvalid;
    logic alert_pin_n;
    logic overheat_pin_n;
  } tmc_state_t;

  // Whole state of the conversion-rate timer.
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } tmc_timer_t;

endpackage

/* verif/tb_temp_monitor_control_regs.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_temp_monitor_control_regs;
  // ------------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_idx = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic bus_busy = 1'b0;
  logic act = 1'b0;
  logic [7:0] rt = 8'h00;
  logic ara = 1'b0;
  logic [7:0] lt = 8'h00;
  logic [4:0] cond = 5'h00;
  logic [3:0] lat = 4'h8;
  logic [7:0] reg_rdata;
  logic reg_rvalid, tmo_rst, adc_start, adc_done, alert_n, hot_n;
  logic sleep, stop, beta, bias, rcan;
  logic [4:0] limit_flags;
  logic [6:0] taddr;
  int miscompares = 0;
  int check_count = 0;

  // The clock runs at 20 MHz.
  always #25 clk = ~clk;

  // Timeout and conversion period are shortened to keep the run short.
  tmc_top #(.TMO_CYCLES(16), .SLOW_CYCLES(2048)) u_tmc_top (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .bus_busy(bus_busy), .bus_activity(act),
    .ara_serviced(ara), .bus_timeout_reset(tmo_rst),
    .adc_start(adc_start), .adc_done(adc_done), .limit_flags(limit_flags),
    .local_sensor_temp(lt), .remote_diode_temp(rt),
    .local_overheat_pin_n_limit(8'h55), .local_overheat_pin_n_hyst(8'h0A),
    .remote_overheat_pin_n_limit(8'h55), .remote_overheat_pin_n_hyst(8'h0A),
    .alert_pin_n(alert_n), .overheat_pin_n(hot_n), .device_sleep(sleep),
    .monitor_stop(stop), .beta_comp_en(beta), .bias_high_sel(bias),
    .res_cancel_en(rcan), .transport_target_address(taddr));

  tmc_adc_model u_tmc_adc_model (
    .clk(clk), .adc_start(adc_start), .adc_done(adc_done),
    .cond(cond), .lat(lat), .limit_flags(limit_flags));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic finish_test();
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Requests are held across exactly one rising edge.
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_idx = i;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_idx = i;
    @(negedge clk);
    reg_rd = 1'b0;
    chk("rvalid", 8'h01, 8'(reg_rvalid));
    chk("rdata", e, reg_rdata);
  endtask

  // Bounded wait for a start (d=0) or done (d=1) pulse.
  // The start pulse already stands when the one-shot write returns.
  task automatic wt(input bit d);
    for (int i = 0; i < 64; i++) begin
      if (d ? adc_done : adc_start) return;
      @(negedge clk);
    end
    miscompares++;
    $display("Error wait expected 1 seen 0");
    finish_test();
  endtask

  // One-shot conversion; the pins have settled when it returns.
  task automatic os(input logic [4:0] c, input logic [7:0] t, input bit b);
    cond = c;
    lt = t;
    wr(8'h0F, 8'h00);
    wt(0);
    if (b) rd(8'h02, 8'h80);
    wt(1);
    repeat (2) @(negedge clk);
  endtask

  task automatic pulse_ara();
    @(negedge clk);
    ara = 1'b1;
    @(negedge clk);
    ara = 1'b0;
    @(negedge clk);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_defaults();
    logic [7:0] ix[8] = '{8'h03, 8'h04, 8'h22, 8'h24, 8'h3B, 8'h3D, 8'h0F, 8'h55};
    logic [7:0] ev[8] = '{8'h00, 8'h08, 8'h01, 8'h01, 8'h8A, 8'h4C, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      rd(ix[i], ev[i]);
    end
    chk("pins", 8'hE8, {alert_n, hot_n, beta, bias, rcan, 3'b000});
    chk("addr", 8'h4C, 8'(taddr));
  endtask

  task automatic t_regs();
    wr(8'h09, 8'hFF);
    rd(8'h03, 8'hC1);
    chk("sleep_stop", 8'h03, 8'({sleep, stop}));
    wr(8'h03, 8'h00);
    rd(8'h03, 8'hC1);
    wr(8'h09, 8'h40);
    chk("sleep_stop", 8'h01, 8'({sleep, stop}));
    wr(8'h0A, 8'h05);
    wr(8'h04, 8'h01);
    rd(8'h04, 8'h05);
    rd(8'h0A, 8'h00);
    wr(8'h3B, 8'h40);
    rd(8'h3B, 8'h40);
    chk("comp", 8'h02, 8'({beta, bias, rcan}));
    wr(8'h3D, 8'hFF);
    rd(8'h3D, 8'h7F);
    chk("addr", 8'h7F, 8'(taddr));
  endtask

  // Alert and overheat with alert-response coupling on.
  task automatic t_alert();
    os(5'h10, 8'h56, 1'b1);
    chk("pins", 8'h00, 8'({alert_n, hot_n}));
    rd(8'h02, 8'h41);
    os(5'h00, 8'h50, 1'b0);
    rd(8'h02, 8'h41);
    chk("pins", 8'h00, 8'({alert_n, hot_n}));
    pulse_ara();
    chk("alert", 8'h01, 8'(alert_n));
    os(5'h01, 8'h40, 1'b0);
    chk("pins", 8'h01, 8'({alert_n, hot_n}));
    rd(8'h02, 8'h04);
    wr(8'h09, 8'hC0);
    chk("alert", 8'h01, 8'(alert_n));
    wr(8'h09, 8'h40);
    chk("alert", 8'h00, 8'(alert_n));
    os(5'h00, 8'h40, 1'b0);
    rd(8'h02, 8'h04);
    pulse_ara();
    chk("alert", 8'h01, 8'(alert_n));
  endtask

  // Fault queue of two with coupling off and a prompt converter.
  task automatic t_queue();
    lat = 4'h1;
    wr(8'h24, 8'h00);
    wr(8'h22, 8'h02);
    rd(8'h22, 8'h03);
    os(5'h02, 8'h00, 1'b0);
    chk("alert", 8'h01, 8'(alert_n));
    os(5'h00, 8'h00, 1'b0);
    os(5'h02, 8'h00, 1'b0);
    chk("alert", 8'h01, 8'(alert_n));
    os(5'h02, 8'h00, 1'b0);
    chk("alert", 8'h00, 8'(alert_n));
    rt = 8'h60;
    os(5'h00, 8'h00, 1'b0);
    rd(8'h02, 8'h0A);
    chk("hot", 8'h00, 8'(hot_n));
    @(negedge clk);
    chk("alert", 8'h01, 8'(alert_n));
  endtask

  // A stalled transaction is cut off only with the timeout enabled.
  task automatic t_timeout();
    int n;
    n = 0;
    bus_busy = 1'b1;
    repeat (40) begin
      @(negedge clk);
      n += tmo_rst;
    end
    chk("tmo_off", 8'h00, 8'(n));
    wr(8'h22, 8'h80);
    n = 0;
    while (tmo_rst !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("tmo_on", 8'h01, 8'(n >= 14 && n <= 18));
    // Bus progress part way through restarts the stall count.
    repeat (10) @(negedge clk);
    act = 1'b1;
    @(negedge clk);
    act = 1'b0;
    n = 0;
    while (tmo_rst !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("tmo_act", 8'h10, 8'(n));
    bus_busy = 1'b0;
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_defaults();
    t_regs();
    t_alert();
    t_queue();
    t_timeout();
    finish_test();
  end
endmodule

`default_nettype wire

/* verif/tmc_adc_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// Converter model
// ------------------------------------------------------------------
// It answers each start pulse with one done pulse lat plus one cycles after the edge that samples it.
module tmc_adc_model (
  // Clock.
  input wire logic clk,
  // Converter handshake.
  input wire logic adc_start,
  output logic adc_done,
  // Result and answer latency, both set by the bench.
  input wire logic [4:0] cond,
  input wire logic [3:0] lat,
  output logic [4:0] limit_flags
);
  // Cycles left until done; negative while idle.
  int n = -1;
  initial adc_done = 1'b0;
  initial limit_flags = 5'h00;
  // The flags only mean something with done, so they toggle otherwise.
  always @(posedge clk) begin
    adc_done <= (n == 0);
    limit_flags <= (n == 0) ? cond : ~limit_flags;
    if (adc_start) begin
      n <= lat;
    end else if (n >= 0) begin
      n <= n - 1;
    end
  end
endmodule

`default_nettype wire
